// file: hdl/tmec_pkg.sv
package tmec_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL_B_MODE = 8'h01;
  localparam logic [7:0] IDX_EVENT_CONTROL = 8'h04;
  localparam logic [7:0] IDX_FLAGS = 8'h06;
  localparam logic [7:0] IDX_STATUS = 8'h07;
  localparam logic [7:0] IDX_CAPTURE = 8'h0C;

  localparam logic [7:0] CONTROL_B_MODE_RESET = 8'h00;
  localparam logic [7:0] EVENT_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_B_MODE_WMASK = 8'h77;
  localparam logic [7:0] EVENT_CONTROL_WMASK = 8'h51;

  localparam int CONTROL_B_MODE_COMPARE_OUTPUT_ENABLE_BIT = 4;
  localparam int CONTROL_B_MODE_MODE_LSB = 0;
  localparam int EV_FILTER_BIT = 6;
  localparam int EV_EDGE_BIT = 4;
  localparam int EV_CAPTURE_EVENT_INPUT_ENABLE_BIT = 0;
  localparam int FLAG_CAPTURE_ON_EVENT_MODE_BIT = 0;
  localparam int STATUS_RUN_BIT = 0;

  // counter_mode_select encodings
  localparam logic [2:0] MODE_PERIODIC = 3'h0;
  localparam logic [2:0] MODE_TIMEOUT = 3'h1;
  localparam logic [2:0] MODE_CAPTURE = 3'h2;
  localparam logic [2:0] MODE_FREQ = 3'h3;
  localparam logic [2:0] MODE_WIDTH = 3'h4;
  localparam logic [2:0] MODE_FREQ_WIDTH = 3'h5;
  localparam logic [2:0] MODE_SINGLE = 3'h6;
  localparam logic [2:0] MODE_EIGHT_BIT_PWM_MODE = 3'h7;

  // samples that must agree before the filtered level moves
  localparam int FILTER_SAMPLES = 4;

  typedef enum logic [1:0] {
    FP_IDLE,
    FP_WAIT_CAPTURE,
    FP_WAIT_STOP
  } tmec_fp_phase_t;

  // one-cycle commands to the neighbouring counter
  typedef struct packed {
    logic start;
    logic stop;
    logic clear_restart;
    logic capture;
  } tmec_act_t;

endpackage

// file: hdl/tmec_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module tmec_sync2 (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // level
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic stage1;
    logic stage2;
  } tmec_sync_t;

  tmec_sync_t q;
  tmec_sync_t n;

  always_comb begin
    n.stage1 = async_in;
    n.stage2 = q.stage1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign sync_out = q.stage2;
endmodule // tmec_sync2
`default_nettype wire

// file: hdl/tmec_noise_filter.sv
`timescale 1ns/1ps
`default_nettype none
module tmec_noise_filter
  import tmec_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // level
  input wire logic raw_in,
  output logic filtered_out
);
  typedef struct packed {
    logic [FILTER_SAMPLES-1:0] hist;
    logic level;
  } tmec_filt_t;

  tmec_filt_t q;
  tmec_filt_t n;

  always_comb begin
    n = q;
    n.hist = {q.hist[FILTER_SAMPLES-2:0], raw_in};
    // level only follows once every sample agrees
    if (&q.hist) begin
      n.level = 1'b1;
    end else if (~|q.hist) begin
      n.level = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign filtered_out = q.level;
endmodule // tmec_noise_filter
`default_nettype wire

// file: hdl/tmec_mode_event.sv
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// RQ1: with compare_output_enable set the timer waveform replaces the port output value on the pin.
// RQ2: software must set the pin direction to output in the port logic for the waveform to show.
// RQ3: the three-bit counter_mode_select picks one of eight counter modes, 0x0 to 0x7.
// RQ4: bit 6 of event_control routes the capture event through a noise filter.
// RQ5: bit 0 of event_control enables the capture event input; cleared, events do nothing.
// RQ6: bit 4 of event_control picks the active event edge, with effects set by the mode.
// RQ7: periodic interrupt and eight-bit pwm modes ignore events of both polarities.
// RQ8: time-out mode starts on the active edge and stops on the other; single-shot starts on it.
// RQ9: capture-on-event mode captures and flags on the active edge only.
// RQ10: frequency mode captures, clears, restarts and flags on the active edge only.
// RQ11: pulse-width mode restarts on the active edge and captures and flags on the other.
// RQ12: combined mode restarts, then captures on the other edge, then stops and flags.
// RQ13: the capture flag clears on a write of 1 or on a capture read in the capture modes.
// RQ14: mode and edge are meant to change only while the timer is stopped.
module tmec_mode_event
  import tmec_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // event channel, asynchronous
  input wire logic event_in,
  // neighbouring counter
  input wire logic waveform_in,
  input wire logic top_reached,
  input wire logic [15:0] capture_value,
  output tmec_act_t counter_act,
  output logic counter_run,
  output logic capture_flag,
  output logic [2:0] counter_mode_select,
  // pin and port logic
  input wire logic port_out_value,
  input wire logic port_dir_out,
  output logic pin_out,
  output logic pin_oe
);

  function automatic logic [7:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx[5:0], 2'b00};
  endfunction

  function automatic logic is_capture_mode(input logic [2:0] m);
    is_capture_mode = (m == MODE_CAPTURE) || (m == MODE_FREQ) ||
                      (m == MODE_WIDTH) || (m == MODE_FREQ_WIDTH);
  endfunction

  typedef struct packed {
    logic [7:0] control_b_mode;
    logic [7:0] event_control;
    logic capture_on_event_mode_flag;
    logic run;
    tmec_fp_phase_t phase;
    logic ev_prev;
    tmec_act_t act;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pin_out;
    logic pin_oe;
  } tmec_state_t;

  tmec_state_t q;
  tmec_state_t n;

  logic ev_sync;
  logic ev_filt;
  logic ev_level;
  logic ev_pos;
  logic ev_neg;
  logic ev_act;
  logic ev_oth;
  logic edge_sel;
  logic [2:0] mode;
  logic setup;
  logic access;
  logic wr_ok;
  logic rd_ok;
  logic mapped;
  logic capture_on_event_mode_set;
  logic [7:0] rd_mux;

  tmec_sync2 u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(event_in),
    .sync_out(ev_sync)
  );

  tmec_noise_filter u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .raw_in(ev_sync),
    .filtered_out(ev_filt)
  );

  assign mode = q.control_b_mode[CONTROL_B_MODE_MODE_LSB +: 3];
  assign edge_sel = q.event_control[EV_EDGE_BIT];
  // filter adds latency, so it is optional
  assign ev_level = q.event_control[EV_FILTER_BIT] ? ev_filt : ev_sync; // [RQ4]
  assign ev_pos = q.event_control[EV_CAPTURE_EVENT_INPUT_ENABLE_BIT] & ev_level & ~q.ev_prev; // [RQ5]
  assign ev_neg = q.event_control[EV_CAPTURE_EVENT_INPUT_ENABLE_BIT] & ~ev_level & q.ev_prev; // [RQ5]
  assign ev_act = edge_sel ? ev_neg : ev_pos; // [RQ6]
  assign ev_oth = edge_sel ? ev_pos : ev_neg; // [RQ6]

  assign setup = psel & ~penable;
  assign access = psel & penable & q.pready;
  assign wr_ok = access & pwrite & ~q.pslverr & pstrb[0];
  assign rd_ok = access & ~pwrite & ~q.pslverr;
  assign mapped = (paddr == byte_addr(IDX_CONTROL_B_MODE)) || (paddr == byte_addr(IDX_EVENT_CONTROL)) ||
                  (paddr == byte_addr(IDX_FLAGS)) || (paddr == byte_addr(IDX_STATUS)) ||
                  (paddr == byte_addr(IDX_CAPTURE));

  always_comb begin
    rd_mux = 8'h00;
    if (paddr == byte_addr(IDX_CONTROL_B_MODE)) begin
      rd_mux = q.control_b_mode;
    end else if (paddr == byte_addr(IDX_EVENT_CONTROL)) begin
      rd_mux = q.event_control;
    end else if (paddr == byte_addr(IDX_FLAGS)) begin
      rd_mux[FLAG_CAPTURE_ON_EVENT_MODE_BIT] = q.capture_on_event_mode_flag;
    end else if (paddr == byte_addr(IDX_STATUS)) begin
      rd_mux[STATUS_RUN_BIT] = q.run;
    end
  end

  always_comb begin
    n = q;
    n.act = '0;
    capture_on_event_mode_set = 1'b0;
    n.ev_prev = ev_level;

    // apb: answer one cycle after setup, no wait states
    n.pready = setup;
    n.pslverr = setup & ~mapped;
    if (setup & ~pwrite) begin
      if (paddr == byte_addr(IDX_CAPTURE)) begin
        n.prdata = {16'h0000, capture_value};
      end else begin
        n.prdata = {24'h00_0000, rd_mux};
      end
    end

    if (wr_ok && paddr == byte_addr(IDX_CONTROL_B_MODE)) begin
      n.control_b_mode = pwdata[7:0] & CONTROL_B_MODE_WMASK;
      n.phase = FP_IDLE; // [RQ14]
    end
    if (wr_ok && paddr == byte_addr(IDX_EVENT_CONTROL)) begin
      n.event_control = pwdata[7:0] & EVENT_CONTROL_WMASK;
      n.phase = FP_IDLE; // [RQ14]
    end
    if (wr_ok && paddr == byte_addr(IDX_FLAGS) && pwdata[FLAG_CAPTURE_ON_EVENT_MODE_BIT]) begin
      n.capture_on_event_mode_flag = 1'b0; // [RQ13]
    end
    if (rd_ok && paddr == byte_addr(IDX_CAPTURE) && is_capture_mode(mode)) begin
      n.capture_on_event_mode_flag = 1'b0; // [RQ13]
    end

    unique case (mode) // [RQ3]
      MODE_PERIODIC, MODE_EIGHT_BIT_PWM_MODE: begin
        n.act = '0; // [RQ7]
      end
      MODE_TIMEOUT: begin
        if (ev_act) begin
          n.act.start = 1'b1; // [RQ8]
          n.run = 1'b1;
        end
        if (ev_oth) begin
          n.act.stop = 1'b1; // [RQ8]
          n.run = 1'b0;
        end
      end
      MODE_CAPTURE: begin
        if (ev_act) begin
          n.act.capture = 1'b1; // [RQ9]
          capture_on_event_mode_set = 1'b1;
        end
      end
      MODE_FREQ: begin
        if (ev_act) begin
          n.act.capture = 1'b1; // [RQ10]
          n.act.clear_restart = 1'b1;
          n.run = 1'b1;
          capture_on_event_mode_set = 1'b1;
        end
      end
      MODE_WIDTH: begin
        if (ev_act) begin
          n.act.clear_restart = 1'b1; // [RQ11]
          n.run = 1'b1;
        end
        if (ev_oth) begin
          n.act.capture = 1'b1; // [RQ11]
          capture_on_event_mode_set = 1'b1;
        end
      end
      MODE_FREQ_WIDTH: begin
        unique case (q.phase) // [RQ12]
          FP_IDLE: begin
            if (ev_act) begin
              n.act.clear_restart = 1'b1;
              n.run = 1'b1;
              n.phase = FP_WAIT_CAPTURE;
            end
          end
          FP_WAIT_CAPTURE: begin
            if (ev_oth) begin
              n.act.capture = 1'b1;
              n.phase = FP_WAIT_STOP;
            end
          end
          FP_WAIT_STOP: begin
            if (ev_act) begin
              n.act.stop = 1'b1;
              n.run = 1'b0;
              capture_on_event_mode_set = 1'b1;
              n.phase = FP_IDLE;
            end
          end
          default: begin
            n.phase = FP_IDLE;
          end
        endcase
      end
      MODE_SINGLE: begin
        if (ev_act) begin
          n.act.start = 1'b1; // [RQ8]
          n.run = 1'b1;
        end else if (top_reached) begin
          n.run = 1'b0;
        end
      end
    endcase

    // a capture in the same cycle as a clear keeps the flag set
    if (capture_on_event_mode_set) begin
      n.capture_on_event_mode_flag = 1'b1; // [RQ13]
    end

    n.pin_out = q.control_b_mode[CONTROL_B_MODE_COMPARE_OUTPUT_ENABLE_BIT] ? waveform_in : port_out_value; // [RQ1]
    n.pin_oe = port_dir_out; // [RQ2]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.control_b_mode <= CONTROL_B_MODE_RESET;
      q.event_control <= EVENT_CONTROL_RESET;
      q.phase <= FP_IDLE;
    end else begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign counter_act = q.act;
  assign counter_run = q.run;
  assign capture_flag = q.capture_on_event_mode_flag;
  assign counter_mode_select = mode;
  assign pin_out = q.pin_out;
  assign pin_oe = q.pin_oe;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_pin_override: assert property ( // [RQ1]
    q.control_b_mode[CONTROL_B_MODE_COMPARE_OUTPUT_ENABLE_BIT] && $stable(q.control_b_mode) |=> pin_out == $past(waveform_in))
    else $error("waveform not on pin while output enabled");

  chk_event_gate: assert property ( // [RQ5]
    !q.event_control[EV_CAPTURE_EVENT_INPUT_ENABLE_BIT] |=> counter_act == '0)
    else $error("counter action while event input disabled");

  chk_idle_modes: assert property ( // [RQ7]
    (mode == MODE_PERIODIC || mode == MODE_EIGHT_BIT_PWM_MODE) |=> counter_act == '0 && $stable(counter_run))
    else $error("event acted in periodic or pwm mode");

  chk_timeout_start: assert property ( // [RQ8]
    mode == MODE_TIMEOUT && ev_act |=> counter_act.start && counter_run)
    else $error("timeout mode did not start on active edge");

  chk_capture_other: assert property ( // [RQ9]
    mode == MODE_CAPTURE && ev_oth && !ev_act |=> !counter_act.capture)
    else $error("capture on inactive edge");

  chk_freq_capture: assert property ( // [RQ10]
    mode == MODE_FREQ && ev_act |=> counter_act.capture && counter_act.clear_restart
      && capture_flag)
    else $error("frequency mode active edge incomplete");

  chk_width_capture: assert property ( // [RQ11]
    mode == MODE_WIDTH && ev_oth |=> counter_act.capture && !counter_act.clear_restart)
    else $error("pulse width capture edge wrong");

  chk_fw_stop: assert property ( // [RQ12]
    mode == MODE_FREQ_WIDTH && q.phase == FP_WAIT_STOP && ev_act
      |=> counter_act.stop && !counter_run && capture_flag && q.phase == FP_IDLE)
    else $error("combined mode second edge did not stop");

  chk_flag_set_wins: assert property ( // [RQ13]
    capture_on_event_mode_set |=> capture_flag ##1 (capture_flag || $past(wr_ok) || $past(rd_ok)))
    else $error("capture flag lost");

  chk_apb_answer: assert property (
    setup |=> pready ##1 !pready)
    else $error("apb answer not one cycle");

  cov_freq_measure: cover property (mode == MODE_FREQ && ev_act);
  cov_fw_full: cover property (
    mode == MODE_FREQ_WIDTH && q.phase == FP_WAIT_STOP && ev_act);
  cov_flag_read_clear: cover property (
    capture_flag && rd_ok && paddr == byte_addr(IDX_CAPTURE) ##1 !capture_flag);
  cov_filter_on: cover property (q.event_control[EV_FILTER_BIT] && ev_pos);

endmodule // tmec_mode_event
`default_nettype wire

// file: verification/tmec_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module tmec_far_end (
  // clock
  input wire logic pclk,
  // bench request
  input wire logic ev_req,
  // event channel and pin
  output logic event_in,
  output logic waveform_in,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_level
);
  logic [2:0] div_r = 3'h0;
  initial event_in = 1'b0;
  initial pin_level = 1'b0;
  always @(posedge pclk) begin
    event_in <= ev_req;
    div_r <= div_r + 3'h1;
    // a released pin floats: show the inverse of its last level
    pin_level <= pin_oe ? pin_out : ~pin_level;
  end
  assign waveform_in = div_r[2];
endmodule // tmec_far_end
`default_nettype wire

// file: verification/timer_mode_event_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module timer_mode_event_control_tb_top;
  import tmec_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ev_req = 1'b0;
  logic event_in;
  logic waveform_in;
  logic [15:0] capture_value = 16'hA5C3;
  tmec_act_t counter_act;
  logic counter_run;
  logic capture_flag;
  logic [2:0] counter_mode_select;
  logic port_out_value = 1'b0;
  logic port_dir_out = 1'b0;
  logic pin_out;
  logic pin_oe;
  logic pin_level;
  int num_errors = 0;
  int num_checks = 0;

  always #2.5 pclk = ~pclk;

  tmec_mode_event i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_in(event_in), .waveform_in(waveform_in),
    .top_reached(1'b0), .capture_value(capture_value), .counter_act(counter_act),
    .counter_run(counter_run), .capture_flag(capture_flag),
    .counter_mode_select(counter_mode_select), .port_out_value(port_out_value),
    .port_dir_out(port_dir_out), .pin_out(pin_out), .pin_oe(pin_oe));

  tmec_far_end i_far (.pclk(pclk), .ev_req(ev_req), .event_in(event_in),
    .waveform_in(waveform_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level));

  task end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", name, exp, got);
    end
  endtask

  task chk_bit(input string name, input logic exp, input logic got);
    chk(name, {31'h0, exp}, {31'h0, got});
  endtask

  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input logic [3:0] st,
           output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= wd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    chk_bit("pready", 1'b1, pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, 4'hF, r, e);
  endtask

  task rd(input logic [7:0] idx, output logic [31:0] r);
    logic e;
    apb(1'b0, idx, 32'h0000_0000, 4'hF, r, e);
  endtask

  function automatic logic [3:0] exp_act(input logic [2:0] m, input int i, input logic en);
    if (!en) return 4'h0;
    case (m)
      MODE_TIMEOUT: return (i == 1) ? 4'b0100 : 4'b1000;
      MODE_CAPTURE: return (i == 1) ? 4'b0000 : 4'b0001;
      MODE_FREQ: return (i == 1) ? 4'b0000 : 4'b0011;
      MODE_WIDTH: return (i == 1) ? 4'b0001 : 4'b0010;
      MODE_FREQ_WIDTH: return (i == 0) ? 4'b0010 : ((i == 1) ? 4'b0001 : 4'b0100);
      MODE_SINGLE: return (i == 1) ? 4'b0000 : 4'b1000;
      default: return 4'h0;
    endcase
  endfunction

  task collect(output logic [3:0] s);
    s = 4'h0;
    repeat (14) begin
      @(negedge pclk);
      s = s | counter_act;
    end
  endtask

  task t_regs;
    logic [31:0] r;
    logic e;
    rd(IDX_CONTROL_B_MODE, r);
    chk("control_b_mode reset", {24'h0, CONTROL_B_MODE_RESET}, r);
    rd(IDX_EVENT_CONTROL, r);
    chk("event_control reset", {24'h0, EVENT_CONTROL_RESET}, r);
    wr(IDX_CONTROL_B_MODE, 32'hFFFF_FFFF);
    rd(IDX_CONTROL_B_MODE, r);
    chk("control_b_mode bits", {24'h0, CONTROL_B_MODE_WMASK}, r);
    wr(IDX_EVENT_CONTROL, 32'hFFFF_FFFF);
    apb(1'b1, IDX_EVENT_CONTROL, 32'h0000_0000, 4'h0, r, e);
    rd(IDX_EVENT_CONTROL, r);
    chk("event_control bits", {24'h0, EVENT_CONTROL_WMASK}, r);
    apb(1'b0, 8'h3F, 32'h0000_0000, 4'hF, r, e);
    chk_bit("unmapped", 1'b1, e);
    wr(IDX_CONTROL_B_MODE, 32'h0000_0000);
    wr(IDX_EVENT_CONTROL, 32'h0000_0000);
  endtask

  task t_pin;
    logic w;
    port_dir_out <= 1'b1;
    port_out_value <= 1'b1;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk_bit("pin port", 1'b1, pin_out);
    chk_bit("pin level", 1'b1, pin_level);
    wr(IDX_CONTROL_B_MODE, 32'h0000_0010);
    repeat (2) @(posedge pclk);
    repeat (16) begin
      @(negedge pclk);
      w = waveform_in;
      @(negedge pclk);
      chk_bit("pin wave", w, pin_out);
    end
    wr(IDX_CONTROL_B_MODE, 32'h0000_0000);
    port_dir_out <= 1'b0;
    repeat (3) @(negedge pclk);
    chk_bit("pin oe", 1'b0, pin_oe);
  endtask

  task run_mode(input logic [2:0] m, input logic e, input logic en, input logic filt);
    logic [31:0] r;
    logic [3:0] s;
    logic f;
    wr(IDX_EVENT_CONTROL, {27'h0, e, 4'h0});
    ev_req <= e;
    repeat (12) @(posedge pclk);
    wr(IDX_CONTROL_B_MODE, {29'h0, m});
    wr(IDX_FLAGS, 32'h0000_0001);
    wr(IDX_EVENT_CONTROL, {25'h0, filt, 1'b0, e, 3'h0, en});
    for (int i = 0; i < 3; i++) begin
      @(posedge pclk);
      ev_req <= (i == 1) ? e : ~e;
      collect(s);
      chk("act", {28'h0, exp_act(m, i, en)}, {28'h0, s});
    end
    chk("mode out", {29'h0, m}, {29'h0, counter_mode_select});
    // run level after the third edge, in the modes that set or clear it
    if (en && m != MODE_PERIODIC && m != MODE_EIGHT_BIT_PWM_MODE && m != MODE_CAPTURE) begin
      chk_bit("run out", m != MODE_FREQ_WIDTH, counter_run);
      rd(IDX_STATUS, r);
      chk("run status", {31'h0, m != MODE_FREQ_WIDTH}, r);
    end
    f = en && m >= MODE_CAPTURE && m <= MODE_FREQ_WIDTH;
    chk_bit("flag", f, capture_flag);
    if (f) begin
      if (m[0]) begin
        rd(IDX_CAPTURE, r);
        chk("capture", 32'h0000_A5C3, r);
      end else begin
        wr(IDX_FLAGS, 32'h0000_0001);
      end
      @(negedge pclk);
      chk_bit("flag clear", 1'b0, capture_flag);
    end
  endtask

  task t_glitch;
    logic [3:0] s;
    ev_req <= 1'b0;
    wr(IDX_CONTROL_B_MODE, {29'h0, MODE_CAPTURE});
    wr(IDX_EVENT_CONTROL, 32'h0000_0041);
    repeat (12) @(posedge pclk);
    ev_req <= 1'b1;
    repeat (2) @(posedge pclk);
    ev_req <= 1'b0;
    collect(s);
    chk("glitch", 32'h0000_0000, {28'h0, s});
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_pin;
    for (int m = 0; m < 8; m++) begin
      for (int e = 0; e < 2; e++) begin
        run_mode(m[2:0], e[0], 1'b1, 1'b0);
      end
    end
    run_mode(MODE_FREQ, 1'b0, 1'b0, 1'b0);
    run_mode(MODE_WIDTH, 1'b1, 1'b1, 1'b1);
    t_glitch;
    end_sim;
  end

  // whole run needs roughly 1.5k cycles
  initial begin
    #200_000;
    num_errors++;
    end_sim;
  end
endmodule // timer_mode_event_control_tb_top
`default_nettype wire
